// file: logic/pes_event_select.sv
`timescale 1ns/1ps
module pes_event_select #(
  parameter int SAMPLE_CYCLES = pes_pkg::SAMPLE_CYCLES
) (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire pes_pkg::pes_sel_t         sel0,
  input  wire pes_pkg::pes_sel_t         sel1,
  input  wire pes_pkg::pes_evt_t         evt,
  input  wire logic                      temp_above_trip,
  output logic [pes_pkg::INC_W-1:0]      prog_inc0,
  output logic [pes_pkg::INC_W-1:0]      prog_inc1,
  output logic                           core_active_cycles_fixed,
  output logic                           throttle,
  output logic [pes_pkg::PEND_W-1:0]     pending_reads
);

  // ----------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------
  logic                      trip_pulse;
  logic [pes_pkg::PEND_W-1:0] pend_reg;
  logic [pes_pkg::PEND_W-1:0] pend_next;
  logic [pes_pkg::INC_W-1:0]  inc0_reg;
  logic [pes_pkg::INC_W-1:0]  inc1_reg;
  logic                       fixed_reg;

  pes_thermal #(
    .SAMPLE_CYCLES (SAMPLE_CYCLES)
  ) u_thermal (
    .mclk            (mclk),
    .rst             (rst),
    .temp_above_trip (temp_above_trip),
    .trip_pulse      (trip_pulse),
    .throttle        (throttle)
  );

  // ----------------------------------------------------------------
  // Halt qualification
  // ----------------------------------------------------------------
  // The bus clock tick is a core-clock pulse, so bus events count
  // ticks rather than core cycles.
  wire core_active  = !evt.core_halted;
  wire bus_active   = evt.bus_clk_tick && core_active;
  wire solo_core    = bus_active && evt.other_core_halted;

  // ----------------------------------------------------------------
  // Pending line read tracking
  // ----------------------------------------------------------------
  // A read issued and completed in one cycle leaves a count that is neither empty nor full unchanged;
  // saturation guards against a wrap if the bus misbehaves.
  wire pend_inc = evt.line_read_issue && !(&pend_reg);
  wire pend_dec = evt.line_read_done && (pend_reg != '0);

  assign pend_next = pend_reg + {{(pes_pkg::PEND_W-1){1'b0}}, pend_inc}
                   - {{(pes_pkg::PEND_W-1){1'b0}}, pend_dec};

  always_ff @(posedge mclk)
  begin
    if (rst)
      pend_reg <= '0;
    else
      pend_reg <= pend_next;
  end

  // ----------------------------------------------------------------
  // Selector decoding
  // ----------------------------------------------------------------
  // A defined code other than the bus queue code with a foreign mask matches
  // nothing, so it counts nothing rather than falling back to a neighbouring event.
  function automatic logic sel_hit(
    input pes_pkg::pes_sel_t s,
    input logic [7:0]        code,
    input logic [7:0]        mask
  );
    return (s.event_code == code) && (s.unit_mask == mask);
  endfunction : sel_hit

  // The bus queue is shared by both threads, so the same total is
  // reported whatever the any-thread qualifier or unit mask says.
  function automatic logic sel_occ(
    input pes_pkg::pes_sel_t s
  );
    return s.event_code == pes_pkg::EV_BUS_OUTSTAND;
  endfunction : sel_occ

  function automatic logic [pes_pkg::INC_W-1:0] pick_inc(
    input logic                       occ,
    input logic                       flag,
    input logic [pes_pkg::PEND_W-1:0] pend
  );
    logic [pes_pkg::INC_W-1:0] r;
    r = {{(pes_pkg::INC_W-1){1'b0}}, flag};
    if (occ)
      r = pes_pkg::INC_W'(pend);
    return r;
  endfunction : pick_inc

  // ----------------------------------------------------------------
  // Counter 0 event selection
  // ----------------------------------------------------------------
  wire                       hit_trip0;
  wire                       hit_core0;
  wire                       hit_bus0;
  wire                       hit_solo0;
  wire                       hit_load0;
  wire                       hit_store0;
  wire                       hit_occ0;
  wire                       flag0;
  wire [pes_pkg::INC_W-1:0]  inc0_next;

  assign hit_trip0  = sel_hit(sel0, pes_pkg::EV_THERMAL,
                              pes_pkg::UM_THERMAL);
  assign hit_core0  = sel_hit(sel0, pes_pkg::EV_UNHALTED,
                              pes_pkg::UM_CORE);
  assign hit_bus0   = sel_hit(sel0, pes_pkg::EV_UNHALTED,
                              pes_pkg::UM_BUS);
  assign hit_solo0  = sel_hit(sel0, pes_pkg::EV_UNHALTED,
                              pes_pkg::UM_NO_OTHER);
  assign hit_load0  = sel_hit(sel0, pes_pkg::EV_L1D,
                              pes_pkg::UM_LOAD);
  assign hit_store0 = sel_hit(sel0, pes_pkg::EV_L1D,
                              pes_pkg::UM_STORE);
  assign hit_occ0   = sel_occ(sel0);

  // Hits are mutually exclusive, so an undefined pair leaves all low.
  assign flag0 = (hit_trip0  && trip_pulse)
              || (hit_core0  && core_active)
              || (hit_bus0   && bus_active)
              || (hit_solo0  && solo_core)
              || (hit_load0  && evt.load_cacheable)
              || (hit_store0 && evt.store_cacheable);
  assign inc0_next = pick_inc(hit_occ0, flag0, pend_reg);

  // ----------------------------------------------------------------
  // Counter 1 event selection
  // ----------------------------------------------------------------
  wire                       hit_trip1;
  wire                       hit_core1;
  wire                       hit_bus1;
  wire                       hit_solo1;
  wire                       hit_load1;
  wire                       hit_store1;
  wire                       hit_occ1;
  wire                       flag1;
  wire [pes_pkg::INC_W-1:0]  inc1_next;

  assign hit_trip1  = sel_hit(sel1, pes_pkg::EV_THERMAL,
                              pes_pkg::UM_THERMAL);
  assign hit_core1  = sel_hit(sel1, pes_pkg::EV_UNHALTED,
                              pes_pkg::UM_CORE);
  assign hit_bus1   = sel_hit(sel1, pes_pkg::EV_UNHALTED,
                              pes_pkg::UM_BUS);
  assign hit_solo1  = sel_hit(sel1, pes_pkg::EV_UNHALTED,
                              pes_pkg::UM_NO_OTHER);
  assign hit_load1  = sel_hit(sel1, pes_pkg::EV_L1D,
                              pes_pkg::UM_LOAD);
  assign hit_store1 = sel_hit(sel1, pes_pkg::EV_L1D,
                              pes_pkg::UM_STORE);
  assign hit_occ1   = sel_occ(sel1);

  assign flag1 = (hit_trip1  && trip_pulse)
              || (hit_core1  && core_active)
              || (hit_bus1   && bus_active)
              || (hit_solo1  && solo_core)
              || (hit_load1  && evt.load_cacheable)
              || (hit_store1 && evt.store_cacheable);
  assign inc1_next = pick_inc(hit_occ1, flag1, pend_reg);

  // ----------------------------------------------------------------
  // Increment registers
  // ----------------------------------------------------------------
  // Registering every increment keeps the counter adders off the
  // decode path, at the cost of one cycle of latency.
  always_ff @(posedge mclk)
  begin
    if (rst)
      inc0_reg <= '0;
    else
      inc0_reg <= inc0_next;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      inc1_reg <= '0;
    else
      inc1_reg <= inc1_next;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      fixed_reg <= 1'b0;
    else
      fixed_reg <= core_active;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prog_inc0                = inc0_reg;
  assign prog_inc1                = inc1_reg;
  assign core_active_cycles_fixed = fixed_reg;
  assign pending_reads            = pend_reg;

endmodule : pes_event_select

// file: logic/pes_pkg.sv
package pes_pkg;

  // ----------------------------------------------------------------
  // Event codes and unit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] EV_THERMAL      = 8'h3B;
  localparam logic [7:0] EV_UNHALTED     = 8'h3C;
  localparam logic [7:0] EV_L1D          = 8'h40;
  localparam logic [7:0] EV_BUS_OUTSTAND = 8'h60;
  localparam logic [7:0] UM_THERMAL      = 8'hC0;
  localparam logic [7:0] UM_CORE         = 8'h00;
  localparam logic [7:0] UM_BUS          = 8'h01;
  localparam logic [7:0] UM_NO_OTHER     = 8'h02;
  localparam logic [7:0] UM_LOAD         = 8'h21;
  localparam logic [7:0] UM_STORE        = 8'h22;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int        PEND_W         = 4;
  localparam int        INC_W          = 4;
  localparam int        CLK_MHZ        = 100;
  localparam int        SAMPLE_US      = 1000;
  localparam int        SAMPLE_CYCLES  = SAMPLE_US * CLK_MHZ;
  localparam int        TMR_W          = 17;
  localparam logic [TMR_W-1:0] TMR_RST = 17'h00000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] event_code;
    logic [7:0] unit_mask;
    logic       any_thread_qualifier;
  } pes_sel_t;

  typedef struct packed {
    logic core_halted;
    logic other_core_halted;
    logic bus_clk_tick;
    logic load_cacheable;
    logic store_cacheable;
    logic line_read_issue;
    logic line_read_done;
  } pes_evt_t;

  typedef enum logic [1:0] {
    PES_NORMAL   = 2'b00,
    PES_THROTTLE = 2'b01
  } pes_therm_t;

endpackage : pes_pkg

// file: logic/pes_thermal.sv
`timescale 1ns/1ps
module pes_thermal #(
  parameter int SAMPLE_CYCLES = pes_pkg::SAMPLE_CYCLES
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic temp_above_trip,
  output logic      trip_pulse,
  output logic      throttle
);

  logic [pes_pkg::TMR_W-1:0] tmr_reg;
  pes_pkg::pes_therm_t       st_reg;
  logic                      trip_reg;
  wire                       sample_now = (tmr_reg == '0);
  wire                       hot        = sample_now && temp_above_trip;
  wire                       cool       = sample_now && !temp_above_trip;

  // ----------------------------------------------------------------
  // Once-per-millisecond temperature sampling
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst || sample_now)
      tmr_reg <= pes_pkg::TMR_W'(SAMPLE_CYCLES - 1);
    else
      tmr_reg <= tmr_reg - 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_reg   <= pes_pkg::PES_NORMAL;
      trip_reg <= 1'b0;
    end
    else
    begin
      trip_reg <= 1'b0;
      unique case (st_reg)
        pes_pkg::PES_NORMAL:
          if (hot)
          begin
            st_reg   <= pes_pkg::PES_THROTTLE;
            trip_reg <= 1'b1;
          end
        pes_pkg::PES_THROTTLE:
          if (cool)
            st_reg <= pes_pkg::PES_NORMAL;
        default:
          st_reg <= pes_pkg::PES_NORMAL;
      endcase
    end
  end

  assign trip_pulse = trip_reg;
  assign throttle   = (st_reg == pes_pkg::PES_THROTTLE);

endmodule : pes_thermal

// file: sim/pes_event_select_properties.sv
`timescale 1ns/1ps
module pes_event_select_properties #(parameter int SAMPLE_CYCLES = 8) (
  input wire logic              mclk,
  input wire logic              rst,
  input wire pes_pkg::pes_sel_t sel0,
  input wire pes_pkg::pes_sel_t sel1,
  input wire pes_pkg::pes_evt_t evt,
  input wire logic [3:0]        prog_inc0,
  input wire logic [3:0]        prog_inc1,
  input wire logic [3:0]        pending_reads,
  input wire logic              core_active_cycles_fixed
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  wire logic [15:0] s0 = sel0[16:1];
  wire logic [15:0] s1 = sel1[16:1];
  wire logic        tk = !evt.core_halted & evt.bus_clk_tick;
  core_cyc_a:
    assert property (s0 == 16'h3C00 && !evt.core_halted |=> prog_inc0 == 4'h1)
      else $error("core cycle");
  fixed_cyc_a:
    assert property (1'b1 |=>
      core_active_cycles_fixed == !$past(evt.core_halted))
      else $error("fixed");
  bus_cyc_a:
    assert property (s0 == 16'h3C01 |=> prog_inc0 == {3'h0, $past(tk)})
      else $error("bus cycle");
  solo_cyc_a:
    assert property (s0 == 16'h3C02 && tk && evt.other_core_halted |=>
      prog_inc0 == 4'h1) else $error("solo");
  load_cnt_a:
    assert property (s0 == 16'h4021 |=>
      prog_inc0 == {3'h0, $past(evt.load_cacheable)}) else $error("load");
  store_cnt_a:
    assert property (s1 == 16'h4022 |=>
      prog_inc1 == {3'h0, $past(evt.store_cacheable)}) else $error("store");
  occupancy_a:
    assert property (sel0.event_code == 8'h60 |=>
      prog_inc0 == $past(pending_reads)) else $error("occupancy");
  pend_up_a:
    assert property (evt[1:0] == 2'h2 && pending_reads != 4'hF |=>
      pending_reads == $past(pending_reads) + 4'h1) else $error("pend");
  cover property (pending_reads == 4'h3);
  cover property (prog_inc0 == 4'h3);
  cover property (prog_inc1 == 4'h1);
endmodule : pes_event_select_properties
bind pes_event_select pes_event_select_properties #(
  .SAMPLE_CYCLES(SAMPLE_CYCLES)) props_i (.mclk(mclk), .rst(rst),
  .sel0(sel0), .sel1(sel1), .evt(evt), .prog_inc0(prog_inc0),
  .prog_inc1(prog_inc1), .pending_reads(pending_reads),
  .core_active_cycles_fixed(core_active_cycles_fixed));

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic              mclk = 1'b0, rst = 1'b1, temp_above_trip = 1'b0;
  logic              throttle, core_active_cycles_fixed;
  logic [3:0]        prog_inc0, prog_inc1, pending_reads;
  pes_pkg::pes_sel_t sel0 = '0, sel1 = '0;
  pes_pkg::pes_evt_t evt = '0;
  int                bad_count = 0, n_checks = 0;
  wire logic [7:0]   pair = {prog_inc0, prog_inc1};
  pes_event_select #(.SAMPLE_CYCLES(8)) pes_event_select_i (.mclk(mclk),
    .rst(rst), .sel0(sel0), .sel1(sel1), .evt(evt), .throttle(throttle),
    .temp_above_trip(temp_above_trip), .prog_inc0(prog_inc0),
    .prog_inc1(prog_inc1), .pending_reads(pending_reads),
    .core_active_cycles_fixed(core_active_cycles_fixed));
  initial forever #5 mclk = ~mclk;
  task automatic give_verdict;
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(logic [7:0] got, exp);
    n_checks++;
    bad_count += int'(got !== exp);
    if (got !== exp)
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
  endtask : chk
  task automatic sc(logic [15:0] a, b, logic [6:0] e, logic [7:0] x);
    sel0 = {a, 1'b0};
    sel1 = {b, 1'b0};
    evt = e;
    @(negedge mclk);
    chk(pair, x);
  endtask : sc
  task automatic t_select;
    sc(16'h3C01, 16'h3C00, 7'h10, 8'h11);
    sc(16'h3C00, 16'h3C01, 7'h00, 8'h10);
    sc(16'h3C00, 16'h3C01, 7'h50, 8'h00);
    sc(16'h3C02, 16'h3C00, 7'h30, 8'h11);
    sc(16'h3C02, 16'h3C00, 7'h10, 8'h01);
    sc(16'h4021, 16'h4022, 7'h08, 8'h10);
    sc(16'h4021, 16'h4022, 7'h04, 8'h01);
    sc(16'h3C03, 16'h4023, 7'h3C, 8'h00);
  endtask : t_select
  // Both counters watch the one shared count, so each half must match.
  task automatic t_pend;
    for (int i = 0; i < 6; i++)
      sc(16'h6000, 16'h6080, 7'(i < 3 ? 2 : 1),
         8'(17 * (i < 3 ? i : 6 - i)));
  endtask : t_pend
  task automatic t_therm;
    logic [7:0] trips = 8'h00;
    sc(16'h3BC0, 16'h3B00, 7'h00, 8'h00);
    temp_above_trip = 1'b1;
    repeat (40) @(negedge mclk) trips += pair;
    chk(trips, 8'h10);
    chk(throttle, 8'h01);
    temp_above_trip = 1'b0;
    for (int i = 0; i < 20 && throttle !== 1'b0; i++) @(negedge mclk);
    chk(throttle, 8'h00);
    if (throttle !== 1'b0)
      give_verdict();
  endtask : t_therm
  initial
  begin
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    t_select();
    t_pend();
    t_therm();
    give_verdict();
  end
endmodule : testbench
